// >>> cbt_pkg.sv
// constants, types and register map of the can bit timing and framing core
package cbt_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ = 10000000; // system clock, one quantum per cycle
  localparam int unsigned SEG_OFS = 1; // effective length = field value + 1
  localparam int unsigned IDLE_BITS = 11; // recessive bits that make the bus idle
  localparam int unsigned ID_W = 11; // identifier width
  localparam int unsigned DLC_W = 4; // length code width
  localparam int unsigned RSV_N = 2; // reserved control bits
  localparam int unsigned MAX_BYTES = 8; // largest data field
  localparam int unsigned BYTE_W = 8; // bits per data byte

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] A_TIMING = 8'h00;
  localparam logic [7:0] A_CTRL = 8'h04;
  localparam logic [7:0] A_TXID = 8'h08;
  localparam logic [7:0] A_TXD0 = 8'h0c;
  localparam logic [7:0] A_TXD1 = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_RXID = 8'h18;
  localparam logic [7:0] A_RXD0 = 8'h1c;
  localparam logic [7:0] A_RXD1 = 8'h20;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned TIM_W = 9; // timing fields in bits 8:0
  localparam int unsigned C_TXREQ = 0; // ctrl: request transmission
  localparam int unsigned C_BOTH = 1; // ctrl: both edges resync
  localparam int unsigned C_SAM = 2; // ctrl: triple sample select
  localparam int unsigned ID_LSB = 0; // id field of txid/rxid
  localparam int unsigned RTR_BIT = 11; // remote request bit
  localparam int unsigned DLC_LSB = 16; // length code field
  localparam int unsigned S_TXDONE = 0; // sticky: frame sent
  localparam int unsigned S_RXDONE = 1; // sticky: frame received
  localparam int unsigned S_ARBLOST = 2; // sticky: arbitration lost
  localparam int unsigned S_IDLE = 3; // bus idle
  localparam int unsigned S_TXING = 4; // transmitting
  localparam int unsigned S_FRM_LSB = 8; // frame field state, 4 bits

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [3:0] ph1; // phase_before_sample field
    logic [2:0] ph2; // phase_after_sample field
    logic [1:0] max_resync_step; // max_resync_step field
  } cbt_timing_s;

  localparam cbt_timing_s TIMING_RST = '{ph1: 4'h5, ph2: 3'h2, max_resync_step: 2'h0};

  typedef enum {SEG_SYNC, SEG_PH1, SEG_PH2} cbt_seg_e;
  typedef enum {F_IDLE, F_ID, F_RTR, F_RSV, F_DLC, F_DATA, F_TAIL} cbt_frame_e;
endpackage

// >>> cbt_sampler.sv
// bus input synchroniser with one or three sample majority
`timescale 1ns/1ns
module cbt_sampler (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // control
  input wire logic triple_sample_select,
  // bus pin
  input wire logic can_rx,
  // conditioned levels
  output logic bus_lvl,
  output logic smp_lvl
);
  logic s1_r, s2_r, s3_r; // synchroniser chain
  logic st_r, st_nxt; // debounced level
  logic [2:0] h_r, h_nxt; // last three quanta, newest in bit 0

  // ****************************************
  // next values
  // ****************************************
  always_comb begin
    st_nxt = (s2_r == s3_r) ? s3_r : st_r;
    h_nxt = {h_r[1:0], st_r};
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      st_r <= 1'b1;
      h_r <= 3'h7;
    end else if (ce) begin
      s1_r <= can_rx;
      s2_r <= s1_r;
      s3_r <= s2_r;
      st_r <= st_nxt;
      h_r <= h_nxt;
    end
  end

  // triple mode delays the line one quantum and votes
  assign bus_lvl = triple_sample_select ? h_r[0] : st_r;
  assign smp_lvl = triple_sample_select ? ((h_r[0] & h_r[1]) | (h_r[0] & h_r[2]) | (h_r[1] & h_r[2]))
                       : st_r;
endmodule

// >>> cbt_core.sv
// can bit timing, edge synchronisation and frame formatting with apb registers
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ns
// How it works
// - bit is sync slot plus two phases
// - sample at end of phase one
// - phase two lasts one to eight quanta
// - resync step one to four quanta
// - triple sample adds one quantum delay
// - hard sync on start of frame
// - resync stretches phase one, trims two
// - phase error sign from segment position
// - small error acts as hard sync
// - one synchronisation per bit
// - edge only if differs from sample
// - falling edge while idle hard syncs
// - rising edges only when enabled
// - transmitter ignores positive error edges unless both edges resync is on
// - never starts an overload frame
// - wired and bus, dominant wins
// - frame fields sent in order
// - identifier msb first, then remote bit
// - remote bit recessive, data dominant
// - two dominant reserved, four bit length
// - data bytes msb first, lowest first
// - majority sampling, one or three
module cbt_core (
  // clock, reset and freeze
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // can pins
  input wire logic can_rx,
  output logic can_tx
);
  // ****************************************
  // declarations
  // ****************************************
  cbt_pkg::cbt_timing_s tim_r, tim_nxt; // timing fields
  logic both_r, both_nxt; // both edge resync
  logic sam_r, sam_nxt; // triple sample select
  logic txreq_r, txreq_nxt; // pending transmission
  logic [31:0] txid_r, txid_nxt; // id, remote, length
  logic [63:0] txd_r, txd_nxt; // transmit bytes, byte0 low
  logic [31:0] rxid_r, rxid_nxt; // received header
  logic [63:0] rxd_r, rxd_nxt; // received bytes
  logic [2:0] stk_r, stk_nxt; // sticky status
  logic [31:0] prd_r, prd_nxt; // read data
  cbt_pkg::cbt_seg_e seg_r, seg_nxt; // bit segment
  logic [4:0] qc_r, qc_nxt; // quantum counter
  logic [4:0] len1_r, len1_nxt; // current phase one length
  logic [3:0] len2_r, len2_nxt; // current phase two length
  logic synced_r, synced_nxt; // synchronised this bit
  logic smp_r, smp_nxt; // value at last sample point
  logic prev_r; // bus level one quantum ago
  cbt_pkg::cbt_frame_e frm_r, frm_nxt; // frame field
  logic [5:0] fc_r, fc_nxt; // bit counter inside field
  logic [3:0] idl_r, idl_nxt; // recessive bits seen while idle
  logic txa_r, txa_nxt; // transmitting this frame
  logic txb_r, txb_nxt; // bit driven on the pin
  logic bus_lvl, smp_lvl; // conditioned bus
  logic wr, rd_setup; // bus strobes
  logic bit_start, smp_pulse; // timing events
  logic sync_ev, hard, small_err; // synchronisation decisions
  logic fall, rise; // edges
  logic [4:0] l1_prog, e_pos; // programmed phase one, positive error
  logic [3:0] l2_prog, e_neg; // programmed phase two, negative error
  logic [2:0] sjw_q; // effective step
  logic [3:0] nbytes; // data bytes in frame
  logic set_txd, set_rxd, set_arb; // sticky set events
  logic bus_idle; // idle reached

  // map an address onto a register
  function automatic logic cbt_mapped(input logic [7:0] a);
    case (a)
      cbt_pkg::A_TIMING, cbt_pkg::A_CTRL, cbt_pkg::A_TXID, cbt_pkg::A_TXD0,
      cbt_pkg::A_TXD1, cbt_pkg::A_STAT, cbt_pkg::A_RXID, cbt_pkg::A_RXD0,
      cbt_pkg::A_RXD1: cbt_mapped = 1'b1;
      default: cbt_mapped = 1'b0;
    endcase
  endfunction

  // ****************************************
  // input conditioning
  // ****************************************
  cbt_sampler u_smp (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .triple_sample_select(sam_r),
    .can_rx(can_rx),
    .bus_lvl(bus_lvl),
    .smp_lvl(smp_lvl)
  );

  // ****************************************
  // apb register group
  // ****************************************
  // zero wait, frozen with the clock enable
  assign pready = ce;
  assign pslverr = psel & penable & ~cbt_mapped(paddr);
  assign prdata = prd_r;
  assign wr = psel & penable & pwrite & ce & cbt_mapped(paddr);
  assign rd_setup = psel & ~penable;

  // register writes, sticky flags, read data capture
  always_comb begin
    tim_nxt = tim_r;
    both_nxt = both_r;
    sam_nxt = sam_r;
    txreq_nxt = txreq_r;
    txid_nxt = txid_r;
    txd_nxt = txd_r;
    prd_nxt = prd_r;
    // hardware clears the request when the frame is out
    if (set_txd) begin
      txreq_nxt = 1'b0;
    end
    // set wins over a simultaneous write one to clear
    stk_nxt = stk_r;
    if (wr && paddr == cbt_pkg::A_STAT) begin
      stk_nxt = stk_r & ~pwdata[2:0];
    end
    stk_nxt = stk_nxt | {set_arb, set_rxd, set_txd};
    if (wr) begin
      case (paddr)
        cbt_pkg::A_TIMING: tim_nxt = pwdata[cbt_pkg::TIM_W-1:0];
        cbt_pkg::A_CTRL: begin
          both_nxt = pwdata[cbt_pkg::C_BOTH];
          sam_nxt = pwdata[cbt_pkg::C_SAM];
          if (pwdata[cbt_pkg::C_TXREQ]) begin
            txreq_nxt = 1'b1;
          end
        end
        cbt_pkg::A_TXID: txid_nxt = {12'h000, pwdata[cbt_pkg::DLC_LSB+:cbt_pkg::DLC_W],
                                     4'h0, pwdata[cbt_pkg::RTR_BIT:cbt_pkg::ID_LSB]};
        cbt_pkg::A_TXD0: txd_nxt[31:0] = pwdata;
        cbt_pkg::A_TXD1: txd_nxt[63:32] = pwdata;
        default: tim_nxt = tim_r;
      endcase
    end
    if (rd_setup) begin
      case (paddr)
        cbt_pkg::A_TIMING: prd_nxt = {23'h000000, tim_r};
        cbt_pkg::A_CTRL: prd_nxt = {29'h00000000, sam_r, both_r, txreq_r};
        cbt_pkg::A_TXID: prd_nxt = txid_r;
        cbt_pkg::A_TXD0: prd_nxt = txd_r[31:0];
        cbt_pkg::A_TXD1: prd_nxt = txd_r[63:32];
        cbt_pkg::A_STAT: prd_nxt = {20'h00000, 4'(frm_r), 3'h0, txa_r, bus_idle, stk_r};
        cbt_pkg::A_RXID: prd_nxt = rxid_r;
        cbt_pkg::A_RXD0: prd_nxt = rxd_r[31:0];
        cbt_pkg::A_RXD1: prd_nxt = rxd_r[63:32];
        default: prd_nxt = 32'h00000000;
      endcase
    end
  end

  // register group flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tim_r <= cbt_pkg::TIMING_RST;
      both_r <= 1'b0;
      sam_r <= 1'b0;
      txreq_r <= 1'b0;
      txid_r <= 32'h00000000;
      txd_r <= 64'h0000000000000000;
      stk_r <= 3'h0;
      prd_r <= 32'h00000000;
    end else if (ce) begin
      tim_r <= tim_nxt;
      both_r <= both_nxt;
      sam_r <= sam_nxt;
      txreq_r <= txreq_nxt;
      txid_r <= txid_nxt;
      txd_r <= txd_nxt;
      stk_r <= stk_nxt;
      prd_r <= prd_nxt;
    end
  end

  // ****************************************
  // bit timing and synchronisation
  // ****************************************
  // software must keep phase lengths legal; no checks here
  assign l1_prog = 5'(tim_r.ph1) + 5'(cbt_pkg::SEG_OFS);
  assign l2_prog = 4'(tim_r.ph2) + 4'(cbt_pkg::SEG_OFS);
  assign sjw_q = 3'(tim_r.max_resync_step) + 3'(cbt_pkg::SEG_OFS);
  assign e_pos = qc_r + 5'h01;
  assign e_neg = len2_r - qc_r[3:0];
  assign fall = prev_r & ~bus_lvl;
  assign rise = ~prev_r & bus_lvl;
  assign bus_idle = (frm_r == cbt_pkg::F_IDLE) && (idl_r == 4'(cbt_pkg::IDLE_BITS));
  assign hard = fall && bus_idle;
  assign small_err = (seg_r == cbt_pkg::SEG_PH1) ? (e_pos <= 5'(sjw_q))
                                                 : (e_neg <= 4'(sjw_q));
  // candidate edge, changed since sample, first this bit
  assign sync_ev = (fall | (rise & both_r))
                   && (bus_lvl != smp_r)
                   && !synced_r
                   && !(txa_r && !both_r && !hard && seg_r == cbt_pkg::SEG_PH1);

  // segment sequencing and phase adjustment
  always_comb begin
    seg_nxt = seg_r;
    qc_nxt = qc_r;
    len1_nxt = len1_r;
    len2_nxt = len2_r;
    synced_nxt = synced_r;
    smp_nxt = smp_r;
    bit_start = 1'b0;
    smp_pulse = 1'b0;
    case (seg_r)
      cbt_pkg::SEG_SYNC: begin
        // one quantum slot for the edge
        seg_nxt = cbt_pkg::SEG_PH1;
        qc_nxt = 5'h00;
      end
      cbt_pkg::SEG_PH1: begin
        if (qc_r == len1_r - 5'h01) begin
          seg_nxt = cbt_pkg::SEG_PH2;
          qc_nxt = 5'h00;
          smp_pulse = 1'b1;
          smp_nxt = smp_lvl;
          len2_nxt = l2_prog;
        end else begin
          qc_nxt = qc_r + 5'h01;
        end
      end
      cbt_pkg::SEG_PH2: begin
        if (qc_r[3:0] == len2_r - 4'h1) begin
          seg_nxt = cbt_pkg::SEG_SYNC;
          qc_nxt = 5'h00;
          bit_start = 1'b1;
          synced_nxt = 1'b0;
          len1_nxt = l1_prog;
        end else begin
          qc_nxt = qc_r + 5'h01;
        end
      end
      default: seg_nxt = cbt_pkg::SEG_SYNC;
    endcase
    if (sync_ev) begin
      synced_nxt = 1'b1;
      if (seg_r == cbt_pkg::SEG_SYNC) begin
        // zero error, timing unchanged
        synced_nxt = 1'b1;
      end else if (hard || small_err) begin
        // this quantum becomes the sync slot
        seg_nxt = cbt_pkg::SEG_PH1;
        qc_nxt = 5'h00;
        len1_nxt = l1_prog;
        smp_pulse = 1'b0;
        smp_nxt = smp_r;
        bit_start = (seg_r == cbt_pkg::SEG_PH2);
      end else if (seg_r == cbt_pkg::SEG_PH1) begin
        len1_nxt = len1_r + 5'(sjw_q);
      end else begin
        len2_nxt = len2_r - 4'(sjw_q);
      end
    end
  end

  // timing flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seg_r <= cbt_pkg::SEG_SYNC;
      qc_r <= 5'h00;
      len1_r <= 5'h01;
      len2_r <= 4'h1;
      synced_r <= 1'b0;
      smp_r <= 1'b1;
      prev_r <= 1'b1;
    end else if (ce) begin
      seg_r <= seg_nxt;
      qc_r <= qc_nxt;
      len1_r <= len1_nxt;
      len2_r <= len2_nxt;
      synced_r <= synced_nxt;
      smp_r <= smp_nxt;
      prev_r <= bus_lvl;
    end
  end

  // ****************************************
  // frame field sequencing
  // ****************************************
  // remote frames carry no data
  assign nbytes = (txid_r[cbt_pkg::RTR_BIT] && txa_r) ? 4'h0 :
                  (rxid_r[cbt_pkg::DLC_LSB+3] ? 4'(cbt_pkg::MAX_BYTES)
                                              : rxid_r[cbt_pkg::DLC_LSB+:4]);

  // field walk on sample points, pin update at bit start
  always_comb begin
    frm_nxt = frm_r;
    fc_nxt = fc_r;
    idl_nxt = idl_r;
    txa_nxt = txa_r;
    txb_nxt = txb_r;
    rxid_nxt = rxid_r;
    rxd_nxt = rxd_r;
    set_txd = 1'b0;
    set_rxd = 1'b0;
    set_arb = 1'b0;
    if (smp_pulse) begin
      // losing a recessive bit to dominant drops to receiver
      if (txa_r && txb_r && !smp_lvl &&
          (frm_r == cbt_pkg::F_ID || frm_r == cbt_pkg::F_RTR)) begin
        txa_nxt = 1'b0;
        set_arb = 1'b1;
      end
      fc_nxt = fc_r + 6'h01;
      case (frm_r)
        cbt_pkg::F_IDLE: begin
          if (!smp_lvl) begin
            frm_nxt = cbt_pkg::F_ID;
            fc_nxt = 6'h00;
            rxid_nxt = 32'h00000000;
          end else begin
            fc_nxt = 6'h00;
            if (idl_r != 4'(cbt_pkg::IDLE_BITS)) begin
              idl_nxt = idl_r + 4'h1;
            end
          end
        end
        cbt_pkg::F_ID: begin
          rxid_nxt[cbt_pkg::ID_LSB+cbt_pkg::ID_W-1-fc_r[3:0]] = smp_lvl;
          if (fc_r == 6'(cbt_pkg::ID_W - 1)) begin
            frm_nxt = cbt_pkg::F_RTR;
            fc_nxt = 6'h00;
          end
        end
        cbt_pkg::F_RTR: begin
          rxid_nxt[cbt_pkg::RTR_BIT] = smp_lvl;
          frm_nxt = cbt_pkg::F_RSV;
          fc_nxt = 6'h00;
        end
        cbt_pkg::F_RSV: begin
          if (fc_r == 6'(cbt_pkg::RSV_N - 1)) begin
            frm_nxt = cbt_pkg::F_DLC;
            fc_nxt = 6'h00;
          end
        end
        cbt_pkg::F_DLC: begin
          rxid_nxt[cbt_pkg::DLC_LSB+cbt_pkg::DLC_W-1-fc_r[1:0]] = smp_lvl;
          if (fc_r == 6'(cbt_pkg::DLC_W - 1)) begin
            fc_nxt = 6'h00;
            frm_nxt = cbt_pkg::F_DATA;
          end
        end
        cbt_pkg::F_DATA: begin
          rxd_nxt[{fc_r[5:3], ~fc_r[2:0]}] = smp_lvl;
          if (fc_r == 6'({nbytes, 3'h0} - 7'h01)) begin
            frm_nxt = cbt_pkg::F_TAIL;
          end
        end
        cbt_pkg::F_TAIL: begin
          // later fields belong to the crc/ack logic
          frm_nxt = cbt_pkg::F_IDLE;
          idl_nxt = 4'h0;
          set_txd = txa_r;
          set_rxd = ~txa_r;
          txa_nxt = 1'b0;
        end
        default: frm_nxt = cbt_pkg::F_IDLE;
      endcase
      // empty data field skips straight to the tail
      if (frm_r == cbt_pkg::F_DLC && frm_nxt == cbt_pkg::F_DATA) begin
        if (rxid_nxt[cbt_pkg::RTR_BIT] || rxid_nxt[cbt_pkg::DLC_LSB+:4] == 4'h0) begin
          frm_nxt = cbt_pkg::F_TAIL;
        end
      end
    end
    if (bit_start) begin
      txb_nxt = 1'b1;
      if (frm_r == cbt_pkg::F_IDLE && bus_idle && txreq_r && !txa_r) begin
        // only data or remote frames are ever started
        txa_nxt = 1'b1;
        txb_nxt = 1'b0;
      end else if (txa_r) begin
        case (frm_r)
          cbt_pkg::F_ID: txb_nxt = txid_r[cbt_pkg::ID_LSB+cbt_pkg::ID_W-1-fc_r[3:0]];
          cbt_pkg::F_RTR: txb_nxt = txid_r[cbt_pkg::RTR_BIT];
          cbt_pkg::F_RSV: txb_nxt = 1'b0;
          cbt_pkg::F_DLC: txb_nxt = txid_r[cbt_pkg::DLC_LSB+cbt_pkg::DLC_W-1-fc_r[1:0]];
          cbt_pkg::F_DATA: txb_nxt = txd_r[{fc_r[5:3], ~fc_r[2:0]}];
          default: txb_nxt = 1'b1;
        endcase
      end
    end
  end

  // frame flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frm_r <= cbt_pkg::F_IDLE;
      fc_r <= 6'h00;
      idl_r <= 4'h0;
      txa_r <= 1'b0;
      txb_r <= 1'b1;
      rxid_r <= 32'h00000000;
      rxd_r <= 64'h0000000000000000;
    end else if (ce) begin
      frm_r <= frm_nxt;
      fc_r <= fc_nxt;
      idl_r <= idl_nxt;
      txa_r <= txa_nxt;
      txb_r <= txb_nxt;
      rxid_r <= rxid_nxt;
      rxd_r <= rxd_nxt;
    end
  end

  // pin drives low for dominant only
  assign can_tx = txb_r;
endmodule

// >>> cbt_assertions.sv
// port checker for the can bit timing core
`timescale 1ns/1ns
module cbt_core_chk (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // apb
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // can pins
  input wire logic can_rx,
  input wire logic can_tx
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic mapped; // aligned word inside the map
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= 8'h20);
  // access phase, and a transfer followed by idle
  sequence acc_s; psel && penable; endsequence
  sequence done_s; psel && penable && pready ##1 !psel; endsequence
  slverr_map_a: assert property (acc_s |-> pslverr == !mapped)
    else $error("slave error wrong for address");
  slverr_idle_a: assert property (!(psel && penable) |-> !pslverr)
    else $error("slave error outside access");
  unmap_zero_a: assert property (acc_s ##0 (!pwrite && !mapped) |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (done_s |-> $stable(prdata))
    else $error("read data moved after transfer");
  tx_rst_a: assert property ($rose(nrst) |-> can_tx)
    else $error("pin not recessive after reset");
  freeze_tx_a: assert property (!ce |=> $stable(can_tx))
    else $error("pin moved while frozen");
  bit_hold_a: assert property ($changed(can_tx) |=> $stable(can_tx) [*2])
    else $error("bit shorter than three quanta");
  sof_bus_a: assert property ($fell(can_tx) |-> $past(can_rx, 2))
    else $error("dominant sent after lost bit");
endmodule
bind cbt_core cbt_core_chk chk_u (.clk(clk), .nrst(nrst), .ce(ce), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .can_rx(can_rx), .can_tx(can_tx));

// >>> cbt_node.sv
// partner node that joins a frame with sof, identifier and remote bit
`timescale 1ns/1ns
module cbt_node #(
  parameter int BIT_Q = 15
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // bus and request
  input wire logic bus,
  input wire logic arm,
  input wire logic [10:0] id,
  // driven level, 1 recessive
  output logic node_tx
);
  logic bus_d; // bus one cycle ago
  logic [11:0] sh; // identifier then remote bit
  int q; // quantum within bit
  int nb; // bits still to send
  // starts only on a falling bus edge from idle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      node_tx <= 1'b1;
      bus_d <= 1'b1;
      q <= 0;
      nb <= 0;
      sh <= 12'h000;
    end else begin
      bus_d <= bus;
      if (nb == 0) begin
        node_tx <= 1'b1; // released, recessive
        if (arm && bus_d && !bus) begin // hard sync on sof edge
          node_tx <= 1'b0; // sof
          sh <= {id, 1'b0}; // id msb first, data frame
          nb <= 13;
          q <= 1;
        end
      end else if (q == BIT_Q) begin
        q <= 1;
        nb <= nb - 1;
        node_tx <= (nb > 1) ? sh[11] : 1'b1;
        sh <= sh << 1;
      end else begin
        q <= q + 1;
      end
    end
  end
endmodule

// >>> cbt_core_tb.sv
// self-checking bench for the can bit timing core
`timescale 1ns/1ns
module cbt_core_tb;
  // ****************************************
  // signals
  // ****************************************
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, can_tx, node_tx, can_rx, er;
  logic arm = 1'b0; // partner joins next frame
  logic [10:0] node_id = 11'h0e0; // partner identifier
  logic [31:0] rd, v;
  logic [10:0] tid;
  int bad_count = 0;
  int cmp_count = 0;
  int seed = 68179;
  int k;
  localparam int BITQ = 1 + 9 + cbt_pkg::SEG_OFS + 3 + cbt_pkg::SEG_OFS; // quanta per bit
  always #50 clk = ~clk;
  assign can_rx = can_tx & node_tx; // wired and
  cbt_core dut_u (.clk(clk), .nrst(nrst), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .can_rx(can_rx), .can_tx(can_tx));
  cbt_node #(.BIT_Q(BITQ)) node_u (.clk(clk), .nrst(nrst), .bus(can_rx), .arm(arm),
    .id(node_id), .node_tx(node_tx));
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, x);
    end
  endtask
  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) bad_count++;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // loads a frame, requests it and compares each bit mid period
  task automatic tx_frame(input logic [10:0] id, input logic rtr, input logic [3:0] dlc,
    input logic [1:0] ctl, input int nchk);
    logic [31:0] d0, d1;
    int q[$];
    int n, nb, lost;
    d0 = $random(seed);
    d1 = $random(seed);
    apb(1'b1, cbt_pkg::A_TXID, {12'h0, dlc, 4'h0, rtr, id});
    apb(1'b1, cbt_pkg::A_TXD0, d0);
    apb(1'b1, cbt_pkg::A_TXD1, d1);
    q.push_back(0);
    for (n = 10; n >= 0; n--) q.push_back(id[n]);
    q.push_back(rtr);
    q.push_back(0);
    q.push_back(0);
    for (n = 3; n >= 0; n--) q.push_back(dlc[n]);
    nb = rtr ? 0 : (dlc > 8 ? 8 : dlc);
    for (n = 0; n < nb * 8; n++) begin
      q.push_back(n < 32 ? d0[8 * (n / 8) + 7 - n % 8] : d1[8 * (n / 8 - 4) + 7 - n % 8]);
    end
    lost = 0; // recessive after a lost bit
    for (n = 1; n < q.size(); n++) begin
      if (arm && n < 13 && q[n] == 1 && (n == 12 || node_id[11 - n] == 1'b0)) lost = 1;
      if (lost != 0) q[n] = 1;
    end
    if (nchk == 0) nchk = q.size();
    apb(1'b1, cbt_pkg::A_CTRL, {29'h0, ctl, 1'b1});
    n = 0;
    while (can_tx !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    check(n < 3000, 1);
    repeat (6) @(posedge clk);
    for (n = 0; n < nchk; n++) begin
      check(can_tx, q[n]);
      repeat (BITQ) @(posedge clk);
    end
    // a full eight byte frame of our own lands in the receive bytes too
    if (nb == 8 && nchk == q.size()) begin
      apb(1'b0, cbt_pkg::A_RXD0, 32'h0);
      check(rd, d0);
      apb(1'b0, cbt_pkg::A_RXD1, 32'h0);
      check(rd, d1);
    end
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, cbt_pkg::A_TIMING, 32'h0);
    check(rd, 32'h0a8);
    apb(1'b0, cbt_pkg::A_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    check(rd, 32'h0);
    check({31'h0, er}, 32'h1);
    v = $random(seed) & 32'h1ff;
    apb(1'b1, cbt_pkg::A_TIMING, v);
    apb(1'b0, cbt_pkg::A_TIMING, 32'h0);
    check(rd, v);
    apb(1'b1, cbt_pkg::A_CTRL, 32'h6);
    apb(1'b0, cbt_pkg::A_CTRL, 32'h0);
    check(rd, 32'h6);
    apb(1'b1, cbt_pkg::A_CTRL, 32'h0);
    // frozen enable stretches the access; timing gives 15 quanta
    fork
      apb(1'b1, cbt_pkg::A_TIMING, 32'h12d);
      begin
        ce <= 1'b0;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
      end
    join
    apb(1'b0, cbt_pkg::A_TIMING, 32'h0);
    check(rd, 32'h12d);
    for (k = 0; k < 3; k++) begin
      tid = 11'($random(seed)) & 11'h3ff; // top bit dominant
      tx_frame(tid, k == 1, k == 0 ? 4'h8 : (k == 1 ? 4'h5 : 4'h0), {k == 2, 1'b0}, 0);
      repeat (2 * BITQ) @(posedge clk);
      apb(1'b0, cbt_pkg::A_STAT, 32'h0);
      check(rd[cbt_pkg::S_TXDONE], 1);
      apb(1'b0, cbt_pkg::A_CTRL, 32'h0);
      check(rd, {29'h0, k == 2, 2'b00});
      apb(1'b0, cbt_pkg::A_RXID, 32'h0);
      check(rd, {12'h0, k == 0 ? 4'h8 : (k == 1 ? 4'h5 : 4'h0), 4'h0, k == 1, tid});
      apb(1'b1, cbt_pkg::A_STAT, 32'h7);
    end
    // partner with lower identifier wins arbitration
    arm <= 1'b1;
    tx_frame(11'h0f0, 1'b0, 4'h1, 2'b00, 19);
    arm <= 1'b0;
    apb(1'b0, cbt_pkg::A_STAT, 32'h0);
    check(rd[cbt_pkg::S_ARBLOST], 1);
    apb(1'b0, cbt_pkg::A_RXID, 32'h0);
    check(rd[10:0], node_id);
    stop_test();
  end
  // watchdog
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    stop_test();
  end
endmodule
